// >>> verilog/dbk_consts.vh
// Constants for the three-cycle data break control block
`ifndef DBK_CONSTS_VH
`define DBK_CONSTS_VH

// ********************************************************************
// Word layout
// ********************************************************************
`define DBK_WORD_W      12
`define DBK_WORD_ZERO   12'h000
// Least significant data line (numbered 11 on the bus, bit 0 here)
`define DBK_WORD_LSB    12'h001
// Address bit that turns the word-count address into current-address
`define DBK_CA_BIT      12'h001
// Clears that bit so the word-count address always has it at zero
`define DBK_WC_MASK     12'hFFE
// Default hard-wired word-count address, field 0
`define DBK_WC_ADDR     12'h030

// ********************************************************************
// Buffering
// ********************************************************************
`define DBK_FIFO_DEPTH  16
`define DBK_FIFO_AW     4

// ********************************************************************
// Transfer kinds, one-hot, latched at entry to the transfer cycle
// ********************************************************************
`define DBK_XK_READ     4'h1
`define DBK_XK_WRITE    4'h2
`define DBK_XK_INCR     4'h4
`define DBK_XK_ADD      4'h8

`endif

// >>> verilog/dbk_fifo.v
// Peripheral-to-memory word FIFO for the data break control block
`timescale 1ns/1ps
`include "dbk_consts.vh"

module dbk_fifo #(
  parameter W  = `DBK_WORD_W,
  parameter D  = `DBK_FIFO_DEPTH,
  parameter AW = `DBK_FIFO_AW
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output wire [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready
);

  reg [W-1:0]  mem_reg [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0]   count_reg;
  reg [AW:0]   count_next;
  reg          ready_reg;

  wire push;
  wire pop;

  // Registered so the ready pin comes straight from a flip-flop
  assign in_ready  = ready_reg;
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // ******************************************************************
  // Storage
  // ******************************************************************
  // No reset on the array; only pointers, count and ready carry state
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // ******************************************************************
  // Pointers and occupancy
  // ******************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      ready_reg  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == D[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == D[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != D[AW:0]);
    end
  end

endmodule

// >>> verilog/dbk_incr.v
// Word incrementer with carry out for the data break control block
`timescale 1ns/1ps
`include "dbk_consts.vh"

module dbk_incr #(
  parameter W = `DBK_WORD_W
) (
  input  wire [W-1:0] word_in,
  output wire [W-1:0] word_out,
  output wire         carry_out
);

  wire [W:0] sum;

  assign sum       = {1'b0, word_in} + {{W{1'b0}}, 1'b1};
  assign word_out  = sum[W-1:0];
  assign carry_out = sum[W];

endmodule

// >>> verilog/dbk_ctrl.v
// Three-cycle data break sequencing and data control
`timescale 1ns/1ps
`include "dbk_consts.vh"

module dbk_ctrl #(
  parameter W           = `DBK_WORD_W,
  parameter [11:0] WC_ADDR = `DBK_WC_ADDR,
  parameter FIFO_DEPTH  = `DBK_FIFO_DEPTH,
  parameter FIFO_AW     = `DBK_FIFO_AW
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         break_request,
  input  wire         three_cycle_sel,
  input  wire         data_out_n,
  input  wire         memory_word_increment_n,
  input  wire         interrupt_strobe,
  input  wire         time_pulse_four,
  input  wire         priority_go,
  input  wire         mem_strobe,
  input  wire [W-1:0] memory_buffer,
  input  wire [W-1:0] periph_data,
  input  wire         periph_valid,
  output wire         periph_ready,
  output reg          break_in_progress,
  output reg          processor_control,
  output reg  [W-1:0] break_address_register,
  output reg          address_drive,
  output reg          field_zero,
  output reg  [W-1:0] memory_data_lines,
  output reg          memory_data_drive,
  output reg          add_to_memory,
  output reg          transfer_strobe,
  output reg  [W-1:0] buffered_membuf_lines,
  output reg          buffered_membuf_valid,
  output reg          word_count_overflow,
  output reg          word_count_cycle,
  output reg          current_address_cycle,
  output reg          transfer_cycle
);

  // ******************************************************************
  // States
  // ******************************************************************
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_REQ  = 6'b000010;
  localparam [5:0] ST_WC   = 6'b000100;
  localparam [5:0] ST_CA   = 6'b001000;
  localparam [5:0] ST_XFER = 6'b010000;
  localparam [5:0] ST_HOLD = 6'b100000;

  reg [5:0]   state_reg;
  reg [5:0]   state_next;
  reg [5:0]   resume_reg;
  reg [5:0]   resume_next;
  reg [3:0]   kind_reg;
  reg [3:0]   kind_next;
  reg         done_reg;
  reg         done_next;
  reg [W-1:0] ca_word_reg;

  wire [W-1:0] inc_word;
  wire         inc_carry;
  wire [W-1:0] fifo_data;
  wire         fifo_valid;
  wire         fifo_pop;
  wire         dir_to_periph;
  wire         incr_req;
  wire         move_on;
  wire [3:0]   kind_now;
  wire [W-1:0] wc_addr;

  // ******************************************************************
  // Support blocks
  // ******************************************************************
  dbk_incr #(
    .W         (W)
  ) u_incr (
    .word_in   (memory_buffer),
    .word_out  (inc_word),
    .carry_out (inc_carry)
  );

  dbk_fifo #(
    .W         (W),
    .D         (FIFO_DEPTH),
    .AW        (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (periph_data),
    .in_valid  (periph_valid),
    .in_ready  (periph_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ******************************************************************
  // Data control decode
  // ******************************************************************
  // Grounded level means asserted
  assign dir_to_periph = ~data_out_n;
  assign incr_req      = ~memory_word_increment_n;
  assign kind_now = dir_to_periph ?
                    (incr_req ? `DBK_XK_INCR : `DBK_XK_READ) :
                    (incr_req ? `DBK_XK_ADD : `DBK_XK_WRITE);
  // Even address keeps the current-address word right after it
  assign wc_addr = WC_ADDR & `DBK_WC_MASK;

  // Words leave the FIFO only in write or add transfers
  assign fifo_pop = state_reg[4] & ~done_reg & fifo_valid &
                    (kind_reg[1] | kind_reg[3]);

  // Transfer cycle may not end before its data has moved
  assign move_on = time_pulse_four &
                   (state_reg != ST_XFER || done_reg);

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always @* begin
    state_next  = state_reg;
    resume_next = resume_reg;
    kind_next   = kind_reg;
    done_next   = done_reg;
    case (state_reg)
      ST_IDLE: begin
        if (break_request && interrupt_strobe) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (time_pulse_four && priority_go) begin
          state_next = three_cycle_sel ? ST_WC : ST_XFER;
          kind_next  = kind_now;
          done_next  = 1'b0;
        end
      end
      ST_WC: begin
        if (move_on) begin
          state_next  = priority_go ? ST_CA : ST_HOLD;
          resume_next = ST_CA;
        end
      end
      ST_CA: begin
        if (move_on) begin
          state_next  = priority_go ? ST_XFER : ST_HOLD;
          resume_next = ST_XFER;
          kind_next   = kind_now;
          done_next   = 1'b0;
        end
      end
      ST_XFER: begin
        if (mem_strobe && kind_reg[0]) begin
          done_next = 1'b1;
        end
        if (fifo_pop || kind_reg[2]) begin
          done_next = 1'b1;
        end
        if (move_on) begin
          state_next = break_request ? ST_REQ : ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (time_pulse_four && priority_go) begin
          state_next = resume_reg;
          kind_next  = kind_now;
          done_next  = 1'b0;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ******************************************************************
  // State registers
  // ******************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      resume_reg <= ST_IDLE;
      kind_reg   <= `DBK_XK_READ;
      done_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      resume_reg <= resume_next;
      kind_reg   <= kind_next;
      done_reg   <= done_next;
    end
  end

  // ******************************************************************
  // Bus control and addressing
  // ******************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      break_in_progress      <= 1'b0;
      processor_control      <= 1'b0;
      address_drive          <= 1'b0;
      field_zero             <= 1'b0;
      break_address_register <= `DBK_WORD_ZERO;
      transfer_strobe        <= 1'b0;
      word_count_cycle       <= 1'b0;
      current_address_cycle  <= 1'b0;
      transfer_cycle         <= 1'b0;
    end else begin
      break_in_progress <= (state_next != ST_IDLE);
      // Held only while a cycle owns the bus
      processor_control <= state_next[2] | state_next[3] | state_next[4];
      address_drive     <= state_next[2] | state_next[3] | state_next[4];
      field_zero        <= state_next[2] | state_next[3];
      word_count_cycle      <= state_next[2];
      current_address_cycle <= state_next[3];
      transfer_cycle        <= state_next[4];
      transfer_strobe   <= state_next[4] & ~state_reg[4];
      if (state_next == ST_WC && state_reg != ST_WC) begin
        break_address_register <= wc_addr;
      end else if (state_next == ST_CA && state_reg != ST_CA) begin
        break_address_register <= wc_addr | `DBK_CA_BIT;
      end else if (state_next == ST_XFER && state_reg != ST_XFER) begin
        // Single-cycle devices have no fresh current address
        if (state_reg == ST_REQ && !three_cycle_sel) begin
          break_address_register <= ca_word_reg;
        end else begin
          break_address_register <= ca_word_reg;
        end
      end
    end
  end

  // ******************************************************************
  // Data path
  // ******************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      ca_word_reg           <= `DBK_WORD_ZERO;
      memory_data_lines     <= `DBK_WORD_ZERO;
      memory_data_drive     <= 1'b0;
      add_to_memory         <= 1'b0;
      buffered_membuf_lines <= `DBK_WORD_ZERO;
      buffered_membuf_valid <= 1'b0;
      word_count_overflow   <= 1'b0;
    end else begin
      buffered_membuf_valid <= 1'b0;
      if (state_next != state_reg) begin
        memory_data_drive <= 1'b0;
        add_to_memory     <= 1'b0;
      end
      if (state_reg == ST_WC && mem_strobe) begin
        memory_data_lines   <= inc_word;
        memory_data_drive   <= 1'b1;
        word_count_overflow <= inc_carry;
      end
      if (state_reg == ST_CA && mem_strobe) begin
        memory_data_lines <= inc_word;
        memory_data_drive <= 1'b1;
        ca_word_reg       <= inc_word;
      end
      if (state_reg == ST_XFER && !done_reg) begin
        if (kind_reg[0] && mem_strobe) begin
          buffered_membuf_lines <= memory_buffer;
          buffered_membuf_valid <= 1'b1;
        end
        if (kind_reg[2]) begin
          memory_data_lines <= `DBK_WORD_LSB;
          memory_data_drive <= 1'b1;
        end
        if (fifo_pop) begin
          memory_data_lines <= fifo_data;
          memory_data_drive <= 1'b1;
          add_to_memory     <= kind_reg[3];
        end
      end
      if (state_reg == ST_REQ) begin
        word_count_overflow <= 1'b0;
      end
    end
  end

endmodule

// >>> bench/dbk_ctrl_chk.sv
// Port-level checker for the data break control block
`timescale 1ns/1ps
module dbk_ctrl_chk #(
  parameter [11:0] WC_ADDR = 12'h030
) (
  input logic        clk,
  input logic        rst_n,
  input logic        time_pulse_four,
  input logic        priority_go,
  input logic        three_cycle_sel,
  input logic        mem_strobe,
  input logic [11:0] memory_buffer,
  input logic        data_out_n,
  input logic        memory_word_increment_n,
  input logic        break_in_progress,
  input logic        processor_control,
  input logic [11:0] break_address_register,
  input logic        field_zero,
  input logic [11:0] memory_data_lines,
  input logic        memory_data_drive,
  input logic        transfer_strobe,
  input logic [11:0] buffered_membuf_lines,
  input logic        buffered_membuf_valid,
  input logic        word_count_cycle,
  input logic        current_address_cycle,
  input logic        transfer_cycle
);
  // ****************************
  // Sequencing checks
  // ****************************
  localparam [11:0] WCA = WC_ADDR & 12'hFFE;
  logic [11:0] ca_reg;
  logic        hold_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Single-cycle breaks reuse the last stored address
  always @(posedge clk) begin
    if (!rst_n)
      ca_reg <= 12'h000;
    else if (current_address_cycle && memory_data_drive)
      ca_reg <= memory_data_lines;
  end
  // Marks a refused boundary, so a resume is not taken for a grant
  always @(posedge clk) begin
    if (!rst_n)
      hold_reg <= 1'b0;
    else if (word_count_cycle || current_address_cycle)
      hold_reg <= time_pulse_four && !priority_go;
    else if (transfer_cycle || !break_in_progress)
      hold_reg <= 1'b0;
  end
  AST_WC_ADDR: assert property (
    word_count_cycle && processor_control |-> break_address_register == WCA)
    else $error("word count address wrong");
  AST_CA_ADDR: assert property (
    current_address_cycle && processor_control |->
      break_address_register == (WCA | 12'h001) && field_zero)
    else $error("current address location wrong");
  AST_WC_INC: assert property (
    word_count_cycle && mem_strobe |-> ##[1:2]
      (memory_data_drive && memory_data_lines == memory_buffer + 12'h001))
    else $error("word count not incremented");
  AST_CA_INC: assert property (
    current_address_cycle && mem_strobe |-> ##[1:2]
      (memory_data_drive && memory_data_lines == memory_buffer + 12'h001))
    else $error("current address not incremented");
  AST_XFER_ADDR: assert property (
    transfer_cycle |-> break_address_register == ca_reg)
    else $error("transfer address wrong");
  AST_STROBE: assert property (
    $rose(transfer_cycle) |-> transfer_strobe ##1 !transfer_strobe)
    else $error("transfer strobe not one cycle");
  AST_INCR: assert property (
    $rose(transfer_cycle) && !data_out_n && !memory_word_increment_n |->
      ##[0:2] (memory_data_drive && memory_data_lines == 12'h001))
    else $error("increment line not driven");
  AST_READ: assert property (
    transfer_cycle && mem_strobe && !data_out_n && memory_word_increment_n
      |-> ##[1:2] (buffered_membuf_valid &&
      buffered_membuf_lines == memory_buffer))
    else $error("read word not passed on");
  AST_GRANT: assert property (
    break_in_progress && !processor_control && !word_count_cycle &&
    !current_address_cycle && !transfer_cycle && time_pulse_four &&
    priority_go && !hold_reg |=> ($past(three_cycle_sel) ? word_count_cycle
                                            : transfer_cycle))
    else $error("wrong first cycle at grant");
  AST_NOGO: assert property (
    (word_count_cycle || current_address_cycle) && time_pulse_four &&
    !priority_go |=> !processor_control && !word_count_cycle &&
      !current_address_cycle && !transfer_cycle)
    else $error("cycle advanced without go");
endmodule

bind dbk_ctrl dbk_ctrl_chk #(.WC_ADDR(WC_ADDR)) dbk_ctrl_chk_inst (
  .clk, .rst_n, .time_pulse_four, .priority_go, .three_cycle_sel,
  .mem_strobe, .memory_buffer, .data_out_n, .memory_word_increment_n,
  .break_in_progress, .processor_control, .break_address_register,
  .field_zero, .memory_data_lines, .memory_data_drive, .transfer_strobe,
  .buffered_membuf_lines, .buffered_membuf_valid, .word_count_cycle,
  .current_address_cycle, .transfer_cycle
);

// >>> bench/dbk_periph.sv
// Peripheral-side model for the data break control block
`timescale 1ns/1ps
module dbk_periph (
  input  logic        clk,
  input  logic        periph_ready,
  input  logic        transfer_strobe,
  input  logic [11:0] buffered_membuf_lines,
  input  logic        buffered_membuf_valid,
  output logic        break_request,
  output logic        three_cycle_sel,
  output logic        data_out_n,
  output logic        memory_word_increment_n,
  output logic [11:0] periph_data,
  output logic        periph_valid
);
  // ****************************
  // Peripheral behaviour
  // ****************************
  logic [11:0] rx_word;
  initial begin
    break_request = 1'b0;
    three_cycle_sel = 1'b0;
    data_out_n = 1'b1;
    memory_word_increment_n = 1'b1;
    periph_data = 12'h000;
    periph_valid = 1'b0;
    rx_word = 12'h000;
  end
  // Select and direction levels held for the whole break; break_request drops at the transfer strobe
  task start(input logic three, dn, inn);
    @(posedge clk);
    three_cycle_sel         <= three;
    data_out_n              <= dn;
    memory_word_increment_n <= inn;
    break_request           <= 1'b1;
  endtask
  task push(input logic [11:0] d);
    @(posedge clk);
    periph_data  <= d;
    periph_valid <= 1'b1;
    @(posedge clk);
    while (periph_ready !== 1'b1) @(posedge clk);
    periph_valid <= 1'b0;
    // Released lines must not keep showing the old word
    periph_data  <= ~d;
  endtask
  always @(posedge clk) begin
    if (transfer_strobe)
      break_request <= 1'b0;
    if (buffered_membuf_valid)
      rx_word <= buffered_membuf_lines;
  end
endmodule

// >>> bench/testbench.sv
// Self-checking testbench for the data break control block
`timescale 1ns/1ps
module testbench;
  // ****************************
  // Signals and instances
  // ****************************
  localparam [11:0] WCA = 12'h052;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        interrupt_strobe = 1'b0;
  logic        time_pulse_four = 1'b0;
  logic        priority_go = 1'b0;
  logic        mem_strobe = 1'b0;
  logic [11:0] memory_buffer = 12'h000;
  logic [11:0] cur = 12'h000;
  int          bad_count = 0;
  int          n_checks = 0;
  wire         break_request, three_cycle_sel, data_out_n, periph_valid;
  wire         memory_word_increment_n, periph_ready, break_in_progress;
  wire [11:0]  periph_data, break_address_register, memory_data_lines;
  wire [11:0]  buffered_membuf_lines;
  wire         processor_control, memory_data_drive, add_to_memory;
  wire         transfer_strobe, buffered_membuf_valid, transfer_cycle;
  wire         word_count_cycle, current_address_cycle;
  wire         address_drive, word_count_overflow;
  dbk_ctrl #(.WC_ADDR(WCA)) dbk_ctrl_inst (
    .clk, .rst_n, .break_request, .three_cycle_sel, .data_out_n,
    .memory_word_increment_n, .interrupt_strobe, .time_pulse_four,
    .priority_go, .mem_strobe, .memory_buffer, .periph_data,
    .periph_valid, .periph_ready, .break_in_progress, .processor_control,
    .break_address_register, .address_drive, .field_zero(),
    .memory_data_lines, .memory_data_drive, .add_to_memory,
    .transfer_strobe, .buffered_membuf_lines, .buffered_membuf_valid,
    .word_count_overflow, .word_count_cycle, .current_address_cycle,
    .transfer_cycle);
  dbk_periph dbk_periph_inst (
    .clk, .periph_ready, .transfer_strobe, .buffered_membuf_lines,
    .buffered_membuf_valid, .break_request, .three_cycle_sel, .data_out_n,
    .memory_word_increment_n, .periph_data, .periph_valid);
  always #5 clk = ~clk;
  // ****************************
  // Tasks
  // ****************************
  task chk(input logic [11:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task pulse(input logic go);
    @(posedge clk);
    time_pulse_four <= 1'b1;
    priority_go     <= go;
    @(posedge clk);
    time_pulse_four <= 1'b0;
    priority_go     <= 1'b0;
    #1;
  endtask
  task mem_read(input logic [11:0] w);
    @(posedge clk);
    memory_buffer <= w;
    mem_strobe    <= 1'b1;
    @(posedge clk);
    mem_strobe    <= 1'b0;
    #1;
  endtask
  // One whole break; ng adds refused priority pulses
  task brk(input logic three, dn, inn, ng, input logic [11:0] wc, ca, d);
    dbk_periph_inst.start(three, dn, inn);
    @(posedge clk);
    interrupt_strobe <= 1'b1;
    @(posedge clk);
    interrupt_strobe <= 1'b0;
    #1;
    if (ng) pulse(1'b0);
    chk(processor_control, 1'b0);
    pulse(1'b1);
    if (three) begin
      chk(word_count_cycle, 1'b1);
      chk(break_address_register, WCA);
      mem_read(wc);
      chk(memory_data_lines, wc + 12'h001);
      chk(word_count_overflow, wc == 12'hFFF);
      if (ng) pulse(1'b0);
      chk(word_count_cycle, !ng);
      chk(processor_control, !ng);
      pulse(1'b1);
      chk(break_address_register, WCA | 12'h001);
      mem_read(ca);
      chk(memory_data_lines, ca + 12'h001);
      cur = ca + 12'h001;
      pulse(1'b1);
    end
    chk(transfer_cycle, 1'b1);
    chk(address_drive, 1'b1);
    chk(transfer_strobe, 1'b1);
    chk(break_address_register, cur);
    if (!dn && inn) mem_read(d);
    repeat (4) @(posedge clk);
    #1;
    if (dn || !inn) chk(memory_data_lines, dn ? d : 12'h001);
    else chk(dbk_periph_inst.rx_word, d);
    chk(add_to_memory, dn && !inn);
    pulse(1'b1);
    @(posedge clk);
    #1;
    chk(processor_control, 1'b0);
    chk(break_in_progress, 1'b0);
    chk(address_drive, 1'b0);
  endtask
  task sc_incr3;  // address wraps to zero
    brk(1'b1, 1'b0, 1'b0, 1'b0, 12'h800, 12'hFFF, 12'h000);
  endtask
  task sc_write3;  // word count wraps from all ones
    dbk_periph_inst.push(12'hA5C);
    brk(1'b1, 1'b1, 1'b1, 1'b0, 12'hFFF, 12'h3FF, 12'hA5C);
  endtask
  task sc_read3;
    brk(1'b1, 1'b0, 1'b1, 1'b1, 12'h123, 12'h7FE, 12'h5A3);
  endtask
  task sc_add1;
    dbk_periph_inst.push(12'h7C1);
    brk(1'b0, 1'b1, 1'b0, 1'b1, 12'h000, 12'h000, 12'h7C1);
  endtask
  task sc_fill;  // Fills to refusal, then drains in order
    for (int i = 0; i < 16; i++) dbk_periph_inst.push(12'h100 + 12'(i));
    @(posedge clk);
    #1;
    chk(periph_ready, 1'b0);
    for (int i = 0; i < 16; i++) brk(0, 1, 1, 0, 0, 0, 12'h100 + 12'(i));
    chk(periph_ready, 1'b1);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****************************
  // Sequence
  // ****************************
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    sc_incr3;
    sc_write3;
    sc_read3;
    sc_add1;
    sc_fill;
    stop_test;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
endmodule
